/* design/mode_policy_if.sv */
`timescale 1ns/100ps
interface mode_policy_if;
    logic [3:0] mode_sel;
    logic [3:0] startup_sel;
    logic switch_enable;
    startup_mode_pkg::op_mode_t boot_mode;
    logic fixed;
    logic allow_ext_net;
    logic allow_pu_net;
    logic allow_ext_pu;
    logic run_switch;
    logic restore_prev;

    modport decoder (
        input mode_sel, startup_sel, switch_enable,
        output boot_mode, fixed, allow_ext_net, allow_pu_net, allow_ext_pu,
        output run_switch, restore_prev
    );
    modport user (
        output mode_sel, startup_sel, switch_enable,
        input boot_mode, fixed, allow_ext_net, allow_pu_net, allow_ext_pu,
        input run_switch, restore_prev
    );
endinterface

/* design/startup_mode_cfg.svh */
`ifndef STARTUP_MODE_CFG_SVH
`define STARTUP_MODE_CFG_SVH

// mode selection setting values
`define MSEL_ANY_0 4'h0
`define MSEL_PANEL 4'h1
`define MSEL_EXT_NET 4'h2
`define MSEL_COMB_1 4'h3
`define MSEL_COMB_2 4'h4
`define MSEL_RUN_SW 4'h6
`define MSEL_SW_EN 4'h7
`define MSEL_RESET 4'h0

// communication startup setting values
`define CSU_AS_MSEL 4'h0
`define CSU_NET 4'h1
`define CSU_NET_KEEP 4'h2
`define CSU_PNET 4'hA
`define CSU_PNET_KEEP 4'hC
`define CSU_RESET 4'h0

// restart coasting time value that disables automatic restart
`define COAST_NO_RESTART 14'h270F

`endif

/* design/startup_mode_decode.sv */
`timescale 1ns/100ps
`include "startup_mode_cfg.svh"
module startup_mode_decode (
    mode_policy_if.decoder pol
);
    logic grp_pnet;
    logic start_net;

    // startup setting groups
    assign grp_pnet = (pol.startup_sel == `CSU_PNET) || (pol.startup_sel == `CSU_PNET_KEEP);
    assign start_net = (pol.startup_sel == `CSU_NET) || (pol.startup_sel == `CSU_NET_KEEP);
    assign pol.restore_prev = (pol.startup_sel == `CSU_NET_KEEP) ||
                              (pol.startup_sel == `CSU_PNET_KEEP);

    // boot mode and switching permissions per setting pair
    always_comb begin
        pol.boot_mode = startup_mode_pkg::MODE_EXT;
        pol.fixed = 1'b0;
        pol.allow_ext_net = 1'b0;
        pol.allow_pu_net = 1'b0;
        pol.allow_ext_pu = 1'b0;
        pol.run_switch = 1'b0;
        case (pol.mode_sel)
            `MSEL_PANEL: begin
                pol.boot_mode = startup_mode_pkg::MODE_PU;
                pol.fixed = 1'b1;
            end
            `MSEL_COMB_1, `MSEL_COMB_2: begin
                pol.boot_mode = startup_mode_pkg::MODE_COMB;
                pol.fixed = 1'b1;
            end
            `MSEL_SW_EN: begin
                if (!pol.switch_enable) begin
                    pol.fixed = 1'b1;
                end else begin
                    pol.allow_ext_net = 1'b1;
                    pol.allow_ext_pu = 1'b1;
                    if (start_net) begin
                        pol.boot_mode = startup_mode_pkg::MODE_NET;
                    end
                end
            end
            `MSEL_EXT_NET: begin
                if (grp_pnet) begin
                    pol.boot_mode = startup_mode_pkg::MODE_NET;
                    pol.fixed = 1'b1;
                end else begin
                    pol.allow_ext_net = 1'b1;
                    if (start_net) begin
                        pol.boot_mode = startup_mode_pkg::MODE_NET;
                    end
                end
            end
            `MSEL_ANY_0, `MSEL_RUN_SW: begin
                pol.run_switch = (pol.mode_sel == `MSEL_RUN_SW);
                if (grp_pnet) begin
                    pol.boot_mode = startup_mode_pkg::MODE_NET;
                    pol.allow_pu_net = 1'b1;
                end else begin
                    pol.allow_ext_net = 1'b1;
                    pol.allow_ext_pu = 1'b1;
                    if (start_net) begin
                        pol.boot_mode = startup_mode_pkg::MODE_NET;
                    end
                end
            end
            default: begin
                pol.fixed = 1'b1;
            end
        endcase
    end
endmodule

/* design/startup_mode_pkg.sv */
package startup_mode_pkg;

    // operating modes held in the mode state register
    typedef enum logic [1:0] {
        MODE_EXT,
        MODE_PU,
        MODE_NET,
        MODE_COMB
    } op_mode_t;

    // supervision phases around reset and supply outages
    typedef enum logic [1:0] {
        ST_INIT,
        ST_RUN,
        ST_OUTAGE
    } phase_t;

endpackage

/* design/startup_mode_select.sv */
`timescale 1ns/100ps
`include "startup_mode_cfg.svh"
// Notes on behaviour
// - compute startup mode at power on, restore, reset
// - accept listed setting values, both reset zero
// - sel0: external start, no panel-network direct
// - sel1: panel mode, locked
// - sel2: external start, external-network only
// - sel3/4: combined mode, no changes
// - sel6: switching allowed while running
// - sel7: enable off forces external
// - startup 1/2: network start, else as 0
// - startup 10/12 sel0: network, panel-network switching
// - startup 10/12: sel2 locked network, sel7 external
// - startup 10/12 sel6: panel-network switching while running
// - startup 2/12: restore pre-failure mode
// - startup 1/10: clear start command after restore
// - coast time not 9999: resume running
// - setting changes only while stopped
// - startup writes need group zero or option
// - priority: selection, enable, ext-net, panel-net, ext-panel
// - panel-network input: on panel, off network
// - external-network input: on network, off external
module startup_mode_select (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [3:0] SETTING_DATA_I,
    input wire logic MODE_SEL_WR_I,
    input wire logic COMM_STARTUP_WR_I,
    input wire logic [7:0] USER_GROUP_READ_SETTING_I,
    input wire logic COMM_OPTION_FITTED_I,
    input wire logic [13:0] RESTART_COAST_TIME_SETTING_I,
    input wire logic MOTOR_RUNNING_I,
    input wire logic POWER_FAIL_I,
    input wire logic START_CMD_I,
    input wire logic SWITCH_ENABLE_INPUT_I,
    input wire logic EXTERNAL_NETWORK_SWITCH_ASSIGNED_I,
    input wire logic EXTERNAL_NETWORK_SWITCH_INPUT_I,
    input wire logic PANEL_NETWORK_SWITCH_ASSIGNED_I,
    input wire logic PANEL_NETWORK_SWITCH_INPUT_I,
    input wire logic EXTERNAL_PANEL_SWITCH_ASSIGNED_I,
    input wire logic EXTERNAL_PANEL_SWITCH_INPUT_I,
    input wire logic OPERATOR_PANEL_KEY_I,
    input wire logic MODE_REQ_I,
    input wire logic [1:0] MODE_REQ_VAL_I,
    output logic [1:0] MODE_O,
    output logic [3:0] MODE_SELECT_SETTING_O,
    output logic [3:0] COMM_STARTUP_SETTING_O,
    output logic START_CMD_O,
    output logic RESUME_RUN_O,
    output logic WR_REJECT_O,
    output logic REQ_REJECT_O
);
    mode_policy_if pol();

    logic [3:0] mode_sel_reg;
    logic [3:0] startup_reg;
    startup_mode_pkg::op_mode_t mode_reg;
    startup_mode_pkg::op_mode_t mode_next;
    startup_mode_pkg::phase_t phase_reg;
    logic ran_reg;
    logic block_reg;
    logic resume_reg;
    logic wr_rej_reg;
    logic req_rej_reg;
    logic req_rej_next;
    logic start_reg;
    logic restore_evt;
    logic fail_evt;
    logic may_switch;
    logic block_set;
    logic msel_ok;
    logic csu_ok;
    logic csu_wr_en;

    // legal mode selection values
    function automatic logic valid_msel(input logic [3:0] v);
        valid_msel = (v <= `MSEL_COMB_2) || (v == `MSEL_RUN_SW) || (v == `MSEL_SW_EN);
    endfunction

    // legal startup setting values
    function automatic logic valid_csu(input logic [3:0] v);
        valid_csu = (v == `CSU_AS_MSEL) || (v == `CSU_NET) || (v == `CSU_NET_KEEP) ||
                    (v == `CSU_PNET) || (v == `CSU_PNET_KEEP);
    endfunction

    // whether a move from one mode to another is allowed by the policy
    function automatic logic move_ok(
        input startup_mode_pkg::op_mode_t from,
        input startup_mode_pkg::op_mode_t to,
        input logic en_pn,
        input logic en_en,
        input logic en_ep
    );
        logic pn;
        logic en;
        logic ep;
        pn = ((from == startup_mode_pkg::MODE_PU) && (to == startup_mode_pkg::MODE_NET)) ||
             ((from == startup_mode_pkg::MODE_NET) && (to == startup_mode_pkg::MODE_PU));
        en = ((from == startup_mode_pkg::MODE_EXT) && (to == startup_mode_pkg::MODE_NET)) ||
             ((from == startup_mode_pkg::MODE_NET) && (to == startup_mode_pkg::MODE_EXT));
        ep = ((from == startup_mode_pkg::MODE_EXT) && (to == startup_mode_pkg::MODE_PU)) ||
             ((from == startup_mode_pkg::MODE_PU) && (to == startup_mode_pkg::MODE_EXT));
        move_ok = (from == to) || (pn && en_pn) || (en && en_en) || (ep && en_ep);
    endfunction

    assign pol.mode_sel = mode_sel_reg;
    assign pol.startup_sel = startup_reg;
    assign pol.switch_enable = SWITCH_ENABLE_INPUT_I;

    startup_mode_decode u_decode (
        .pol(pol)
    );

    // supply events and switching window
    assign fail_evt = (phase_reg == startup_mode_pkg::ST_RUN) && POWER_FAIL_I;
    assign restore_evt = (phase_reg == startup_mode_pkg::ST_OUTAGE) && !POWER_FAIL_I;
    assign may_switch = !MOTOR_RUNNING_I || pol.run_switch;
    assign msel_ok = valid_msel(SETTING_DATA_I);
    assign csu_ok = valid_csu(SETTING_DATA_I);
    assign csu_wr_en = (USER_GROUP_READ_SETTING_I == 8'h00) || COMM_OPTION_FITTED_I;

    // phase sequencing: init after reset, outage while supply is lost
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            phase_reg <= startup_mode_pkg::ST_INIT;
        end else begin
            case (phase_reg)
                startup_mode_pkg::ST_INIT: phase_reg <= startup_mode_pkg::ST_RUN;
                startup_mode_pkg::ST_RUN: begin
                    if (POWER_FAIL_I) begin
                        phase_reg <= startup_mode_pkg::ST_OUTAGE;
                    end
                end
                startup_mode_pkg::ST_OUTAGE: begin
                    if (!POWER_FAIL_I) begin
                        phase_reg <= startup_mode_pkg::ST_RUN;
                    end
                end
                default: phase_reg <= startup_mode_pkg::ST_INIT;
            endcase
        end
    end

    // setting storage, writes only while stopped
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_sel_reg <= `MSEL_RESET;
            startup_reg <= `CSU_RESET;
            wr_rej_reg <= 1'b0;
        end else begin
            wr_rej_reg <= 1'b0;
            if (MODE_SEL_WR_I) begin
                if (!MOTOR_RUNNING_I && msel_ok) begin
                    mode_sel_reg <= SETTING_DATA_I;
                end else begin
                    wr_rej_reg <= 1'b1;
                end
            end
            if (COMM_STARTUP_WR_I) begin
                if (!MOTOR_RUNNING_I && csu_ok && csu_wr_en) begin
                    startup_reg <= SETTING_DATA_I;
                end else begin
                    wr_rej_reg <= 1'b1;
                end
            end
        end
    end

    // mode resolution in priority order
    always_comb begin
        mode_next = mode_reg;
        req_rej_next = 1'b0;
        if (pol.fixed) begin
            mode_next = pol.boot_mode;
        end else if (may_switch) begin
            if (EXTERNAL_NETWORK_SWITCH_ASSIGNED_I && pol.allow_ext_net) begin
                mode_next = EXTERNAL_NETWORK_SWITCH_INPUT_I ? startup_mode_pkg::MODE_NET :
                            startup_mode_pkg::MODE_EXT;
            end else if (PANEL_NETWORK_SWITCH_ASSIGNED_I && pol.allow_pu_net) begin
                mode_next = PANEL_NETWORK_SWITCH_INPUT_I ? startup_mode_pkg::MODE_PU :
                            startup_mode_pkg::MODE_NET;
            end else if (EXTERNAL_PANEL_SWITCH_ASSIGNED_I && pol.allow_ext_pu) begin
                mode_next = EXTERNAL_PANEL_SWITCH_INPUT_I ? startup_mode_pkg::MODE_EXT :
                            startup_mode_pkg::MODE_PU;
            end else if (OPERATOR_PANEL_KEY_I && pol.allow_pu_net) begin
                mode_next = (mode_reg == startup_mode_pkg::MODE_PU) ?
                            startup_mode_pkg::MODE_NET : startup_mode_pkg::MODE_PU;
            end else if (MODE_REQ_I) begin
                if (move_ok(mode_reg, startup_mode_pkg::op_mode_t'(MODE_REQ_VAL_I),
                            pol.allow_pu_net, pol.allow_ext_net, pol.allow_ext_pu)) begin
                    mode_next = startup_mode_pkg::op_mode_t'(MODE_REQ_VAL_I);
                end else begin
                    req_rej_next = 1'b1;
                end
            end
        end else if (MODE_REQ_I) begin
            req_rej_next = 1'b1;
        end
        if (pol.fixed && MODE_REQ_I && (MODE_REQ_VAL_I != 2'(pol.boot_mode))) begin
            req_rej_next = 1'b1;
        end
    end

    // mode state register
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_reg <= startup_mode_pkg::MODE_EXT;
            req_rej_reg <= 1'b0;
        end else begin
            req_rej_reg <= 1'b0;
            case (phase_reg)
                startup_mode_pkg::ST_INIT: mode_reg <= pol.boot_mode;
                startup_mode_pkg::ST_OUTAGE: begin
                    if (!POWER_FAIL_I && !pol.restore_prev) begin
                        mode_reg <= pol.boot_mode;
                    end
                end
                startup_mode_pkg::ST_RUN: begin
                    if (!POWER_FAIL_I) begin
                        mode_reg <= mode_next;
                        req_rej_reg <= req_rej_next;
                    end
                end
                default: mode_reg <= startup_mode_pkg::MODE_EXT;
            endcase
        end
    end

    // start command clearing and automatic restart
    assign block_set = restore_evt && START_CMD_I &&
                       ((startup_reg == `CSU_NET) || (startup_reg == `CSU_PNET));
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ran_reg <= 1'b0;
            block_reg <= 1'b0;
            resume_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            if (fail_evt) begin
                ran_reg <= MOTOR_RUNNING_I;
            end
            if (block_set) begin
                block_reg <= 1'b1;
            end else if (!START_CMD_I) begin
                block_reg <= 1'b0;
            end
            start_reg <= START_CMD_I && !POWER_FAIL_I && !block_reg && !block_set;
            resume_reg <= restore_evt && ran_reg &&
                          (RESTART_COAST_TIME_SETTING_I != `COAST_NO_RESTART);
        end
    end

    assign MODE_O = mode_reg;
    assign MODE_SELECT_SETTING_O = mode_sel_reg;
    assign COMM_STARTUP_SETTING_O = startup_reg;
    assign START_CMD_O = start_reg;
    assign RESUME_RUN_O = resume_reg;
    assign WR_REJECT_O = wr_rej_reg;
    assign REQ_REJECT_O = req_rej_reg;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);

    a_boot_after_init: assert property ((phase_reg == startup_mode_pkg::ST_INIT) |=>
        (mode_reg == $past(pol.boot_mode))) else $error("boot mode not loaded");
    a_panel_locked: assert property ((phase_reg == startup_mode_pkg::ST_RUN && !POWER_FAIL_I &&
        mode_sel_reg == `MSEL_PANEL) |=> (mode_reg == startup_mode_pkg::MODE_PU))
        else $error("panel lock broken");
    a_comb_locked: assert property ((phase_reg == startup_mode_pkg::ST_RUN && !POWER_FAIL_I &&
        (mode_sel_reg == `MSEL_COMB_1 || mode_sel_reg == `MSEL_COMB_2)) |=>
        (mode_reg == startup_mode_pkg::MODE_COMB)) else $error("combined lock broken");
    a_forced_external: assert property ((phase_reg == startup_mode_pkg::ST_RUN && !POWER_FAIL_I &&
        mode_sel_reg == `MSEL_SW_EN && !SWITCH_ENABLE_INPUT_I) |=>
        (mode_reg == startup_mode_pkg::MODE_EXT)) else $error("not forced external");
    a_no_direct_hop: assert property ((phase_reg == startup_mode_pkg::ST_RUN && !POWER_FAIL_I &&
        mode_reg == startup_mode_pkg::MODE_PU && !pol.allow_pu_net && !pol.fixed &&
        !EXTERNAL_NETWORK_SWITCH_ASSIGNED_I && !EXTERNAL_PANEL_SWITCH_ASSIGNED_I &&
        MODE_REQ_I && MODE_REQ_VAL_I == 2'h2) |=>
        (mode_reg == startup_mode_pkg::MODE_PU && REQ_REJECT_O))
        else $error("direct panel to network");
    a_restore_prev: assert property ((restore_evt && pol.restore_prev) |=>
        (mode_reg == $past(mode_reg))) else $error("mode not restored");
    a_start_cleared: assert property (block_set |=> (!START_CMD_O [*2]))
        else $error("start not cleared");
    a_resume_run: assert property ((restore_evt && ran_reg &&
        RESTART_COAST_TIME_SETTING_I != `COAST_NO_RESTART) |=> RESUME_RUN_O ##1 !RESUME_RUN_O)
        else $error("no resume pulse");
    a_write_running: assert property ((MOTOR_RUNNING_I && MODE_SEL_WR_I) |=>
        ($stable(mode_sel_reg) && WR_REJECT_O)) else $error("write while running");
    a_startup_guard: assert property ((COMM_STARTUP_WR_I && !COMM_OPTION_FITTED_I &&
        USER_GROUP_READ_SETTING_I != 8'h00) |=> $stable(startup_reg))
        else $error("startup write not guarded");

    c_net_boot: cover property ((phase_reg == startup_mode_pkg::ST_INIT) ##1
        (mode_reg == startup_mode_pkg::MODE_NET));
    c_outage_restore: cover property (fail_evt ##[1:20] restore_evt);
    c_key_toggle: cover property (OPERATOR_PANEL_KEY_I && pol.allow_pu_net ##1
        (mode_reg == startup_mode_pkg::MODE_PU));
endmodule

/* verif/panel_terminal_model.sv */
`timescale 1ns/100ps
// operator panel key and the mode switch terminals
module panel_terminal_model (
    input wire logic clk_i,
    output logic key_o,
    output logic [2:0] asg_o,
    output logic [2:0] lvl_o
);
    // terminals idle unassigned and off
    initial begin
        key_o = 1'b0;
        asg_o = 3'h0;
        lvl_o = 3'h0;
    end
    // one clock press, since a held key toggles every cycle
    task automatic press_key();
        @(posedge clk_i);
        #1 key_o = 1'b1;
        @(posedge clk_i);
        #1 key_o = 1'b0;
    endtask
    // bit 2 ext-net, bit 1 panel-net, bit 0 ext-panel
    task automatic set_terms(input logic [2:0] asg, input logic [2:0] lvl);
        @(posedge clk_i);
        #1 asg_o = asg;
        lvl_o = lvl;
    endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    localparam logic [1:0] EX = startup_mode_pkg::MODE_EXT;
    localparam logic [1:0] PU = startup_mode_pkg::MODE_PU;
    localparam logic [1:0] NT = startup_mode_pkg::MODE_NET;
    localparam logic [1:0] CB = startup_mode_pkg::MODE_COMB;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] data = 4'h0;
    logic msel_wr = 1'b0;
    logic csu_wr = 1'b0;
    logic [7:0] group = 8'h00;
    logic option = 1'b0;
    logic [13:0] coast = 14'h0064;
    logic running = 1'b0;
    logic pfail = 1'b0;
    logic start = 1'b0;
    logic sw_en = 1'b0;
    logic mreq = 1'b0;
    logic [1:0] mval = 2'h0;
    logic key;
    logic [2:0] asg, lvl;
    logic [1:0] mode;
    logic [3:0] msel_q, csu_q;
    logic start_q, resume, wr_rej, req_rej;
    int err_count = 0;
    int num_checks = 0;
    // free running core clock
    always #5 clk = ~clk;
    startup_mode_select DUT (.CORE_CLK_I(clk), .RSTN_I(rst_n), .SETTING_DATA_I(data),
        .MODE_SEL_WR_I(msel_wr), .COMM_STARTUP_WR_I(csu_wr), .USER_GROUP_READ_SETTING_I(group),
        .COMM_OPTION_FITTED_I(option), .RESTART_COAST_TIME_SETTING_I(coast),
        .MOTOR_RUNNING_I(running), .POWER_FAIL_I(pfail), .START_CMD_I(start),
        .SWITCH_ENABLE_INPUT_I(sw_en), .EXTERNAL_NETWORK_SWITCH_ASSIGNED_I(asg[2]),
        .EXTERNAL_NETWORK_SWITCH_INPUT_I(lvl[2]), .PANEL_NETWORK_SWITCH_ASSIGNED_I(asg[1]),
        .PANEL_NETWORK_SWITCH_INPUT_I(lvl[1]), .EXTERNAL_PANEL_SWITCH_ASSIGNED_I(asg[0]),
        .EXTERNAL_PANEL_SWITCH_INPUT_I(lvl[0]), .OPERATOR_PANEL_KEY_I(key), .MODE_REQ_I(mreq),
        .MODE_REQ_VAL_I(mval), .MODE_O(mode), .MODE_SELECT_SETTING_O(msel_q),
        .COMM_STARTUP_SETTING_O(csu_q), .START_CMD_O(start_q), .RESUME_RUN_O(resume),
        .WR_REJECT_O(wr_rej), .REQ_REJECT_O(req_rej));
    panel_terminal_model PANEL (.clk_i(clk), .key_o(key), .asg_o(asg), .lvl_o(lvl));
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // setting write; a trailing cycle lets the mode settle
    task automatic wr(input logic to_csu, input logic [3:0] val, input logic rej);
        data = val;
        msel_wr = !to_csu;
        csu_wr = to_csu;
        tick();
        msel_wr = 1'b0;
        csu_wr = 1'b0;
        check(16'(wr_rej), 16'(rej));
        tick();
    endtask
    // mode request, result one cycle later
    task automatic req(input logic [1:0] val, input logic [1:0] em, input logic rej);
        mval = val;
        mreq = 1'b1;
        tick();
        mreq = 1'b0;
        check(16'({req_rej, mode}), 16'({rej, em}));
        tick();
    endtask
    // supply dip and restoration
    task automatic outage(input logic [1:0] em, input logic er, input logic es);
        logic r;
        pfail = 1'b1;
        repeat (2) tick();
        check(16'(start_q), 16'h0000);
        pfail = 1'b0;
        tick();
        r = resume;
        tick();
        r = r | resume;
        check(16'({start_q, r, mode}), 16'({es, er, em}));
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) tick();
    endtask
    // every value of both settings, plus the write gates
    task automatic t_writes();
        logic [3:0] e;
        logic ok;
        check(16'({mode, msel_q, csu_q, start_q, resume, wr_rej, req_rej}), 16'h0000);
        e = 4'h0;
        for (int i = 0; i < 16; i++) begin
            ok = (i <= 4) || (i == 6) || (i == 7);
            wr(1'b0, 4'(i), !ok);
            e = ok ? 4'(i) : e;
            check(16'(msel_q), 16'(e));
        end
        e = 4'h0;
        for (int i = 0; i < 16; i++) begin
            ok = (i <= 2) || (i == 10) || (i == 12);
            wr(1'b1, 4'(i), !ok);
            e = ok ? 4'(i) : e;
            check(16'(csu_q), 16'(e));
        end
        wr(1'b1, 4'h0, 1'b0);
        wr(1'b0, 4'h0, 1'b0);
        running = 1'b1;
        wr(1'b0, 4'h2, 1'b1);
        wr(1'b1, 4'h1, 1'b1);
        running = 1'b0;
        group = 8'h01;
        wr(1'b1, 4'h1, 1'b1);
        wr(1'b0, 4'h0, 1'b0);
        option = 1'b1;
        wr(1'b1, 4'h1, 1'b0);
        check(16'(csu_q), 16'h0001);
        group = 8'h00;
        option = 1'b0;
        wr(1'b1, 4'h0, 1'b0);
    endtask
    // selection 0 and 6 moves, stopped and running
    task automatic t_sel0();
        req(NT, NT, 1'b0);
        req(PU, NT, 1'b1);
        req(EX, EX, 1'b0);
        req(PU, PU, 1'b0);
        req(NT, PU, 1'b1);
        req(CB, PU, 1'b1);
        req(EX, EX, 1'b0);
        running = 1'b1;
        req(NT, EX, 1'b1);
        running = 1'b0;
        wr(1'b0, 4'h6, 1'b0);
        running = 1'b1;
        req(PU, PU, 1'b0);
        req(EX, EX, 1'b0);
        running = 1'b0;
    endtask
    // locked and restricted selections
    task automatic t_fixed();
        wr(1'b0, 4'h2, 1'b0);
        req(PU, EX, 1'b1);
        req(NT, NT, 1'b0);
        wr(1'b0, 4'h1, 1'b0);
        check(16'(mode), 16'(PU));
        req(EX, PU, 1'b1);
        wr(1'b0, 4'h3, 1'b0);
        req(EX, CB, 1'b1);
        wr(1'b0, 4'h4, 1'b0);
        check(16'(mode), 16'(CB));
        wr(1'b0, 4'h7, 1'b0);
        check(16'(mode), 16'(EX));
        req(NT, EX, 1'b1);
        sw_en = 1'b1;
        req(NT, NT, 1'b0);
        req(EX, EX, 1'b0);
        sw_en = 1'b0;
        wr(1'b0, 4'h0, 1'b0);
    endtask
    // terminal switch levels and their priority
    task automatic t_terms();
        PANEL.set_terms(3'b001, 3'b000);
        tick();
        check(16'(mode), 16'(PU));
        PANEL.set_terms(3'b001, 3'b001);
        tick();
        check(16'(mode), 16'(EX));
        PANEL.set_terms(3'b100, 3'b100);
        tick();
        check(16'(mode), 16'(NT));
        req(EX, NT, 1'b0);
        PANEL.set_terms(3'b100, 3'b000);
        tick();
        check(16'(mode), 16'(EX));
        PANEL.set_terms(3'b110, 3'b110);
        tick();
        check(16'(mode), 16'(NT));
        PANEL.set_terms(3'b000, 3'b000);
    endtask
    // panel-network startup settings
    task automatic t_pnet();
        wr(1'b1, 4'hA, 1'b0);
        outage(NT, 1'b0, 1'b0);
        PANEL.press_key();
        check(16'(mode), 16'(PU));
        PANEL.press_key();
        check(16'(mode), 16'(NT));
        req(EX, NT, 1'b1);
        PANEL.set_terms(3'b010, 3'b010);
        tick();
        check(16'(mode), 16'(PU));
        PANEL.set_terms(3'b010, 3'b000);
        tick();
        check(16'(mode), 16'(NT));
        PANEL.set_terms(3'b000, 3'b000);
        wr(1'b0, 4'h6, 1'b0);
        running = 1'b1;
        PANEL.press_key();
        check(16'(mode), 16'(PU));
        running = 1'b0;
        wr(1'b0, 4'h2, 1'b0);
        check(16'(mode), 16'(NT));
        req(PU, NT, 1'b1);
        sw_en = 1'b1;
        wr(1'b0, 4'h7, 1'b0);
        outage(EX, 1'b0, 1'b0);
        sw_en = 1'b0;
    endtask
    // boot mode table: startup, selection, enable, mode
    task automatic t_boot();
        logic [11:0] tbl [9] = '{12'h102, 12'h000, 12'h122, 12'h020, 12'h162,
                                 12'h060, 12'h176, 12'h170, 12'h000};
        foreach (tbl[i]) begin
            sw_en = tbl[i][2];
            wr(1'b1, tbl[i][11:8], 1'b0);
            wr(1'b0, tbl[i][7:4], 1'b0);
            outage(tbl[i][1:0], 1'b0, 1'b0);
        end
    endtask
    // restore, resume and start clearing
    task automatic t_restore();
        wr(1'b1, 4'h2, 1'b0);
        req(PU, PU, 1'b0);
        outage(PU, 1'b0, 1'b0);
        wr(1'b1, 4'h1, 1'b0);
        running = 1'b1;
        start = 1'b1;
        tick();
        outage(NT, 1'b1, 1'b0);
        coast = 14'h270F;
        outage(NT, 1'b0, 1'b0);
        running = 1'b0;
        coast = 14'h0064;
        wr(1'b1, 4'h2, 1'b0);
        start = 1'b0;
        tick();
        start = 1'b1;
        repeat (2) tick();
        outage(NT, 1'b0, 1'b1);
        start = 1'b0;
        wr(1'b1, 4'hC, 1'b0);
        PANEL.press_key();
        outage(PU, 1'b0, 1'b0);
        wr(1'b1, 4'hA, 1'b0);
        start = 1'b1;
        repeat (2) tick();
        outage(NT, 1'b0, 1'b0);
        start = 1'b0;
        do_reset();
        check(16'({mode, msel_q, csu_q}), 16'h0000);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset();
        t_writes();
        t_sel0();
        t_fixed();
        t_terms();
        t_pnet();
        t_boot();
        t_restore();
        conclude();
    end
    // watchdog, well past the expected run length
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule
